/* rtl/fsp_pkg.sv */
// Constants for the flash self-programming partition and sequencer
package fsp_pkg;
    // ==========================================================
    // Control and status bit positions
    localparam int GO_BIT = 0;
    localparam int ERASE_BIT = 1;
    localparam int WRITE_BIT = 2;
    localparam int REEN_BIT = 4;
    localparam int BUSY_BIT = 6;
    localparam logic [7:0] CSR_RESET = 8'h00;
    // ==========================================================
    // Small variant layout (word addresses)
    localparam logic [13:0] SML_BOOT_11 = 14'h1f80;
    localparam logic [13:0] SML_BOOT_10 = 14'h1f00;
    localparam logic [13:0] SML_BOOT_01 = 14'h1e00;
    localparam logic [13:0] SML_BOOT_00 = 14'h1c00;
    localparam logic [13:0] SML_NONCONCURRENT_REGION_START = 14'h1c00;
    localparam logic [13:0] SML_PC_MASK = 14'h1fff;
    localparam logic [7:0] SML_PAGE_MASK = 8'h7f;
    // ==========================================================
    // Middle variant layout (word addresses)
    localparam logic [13:0] MID_BOOT_11 = 14'h3f00;
    localparam logic [13:0] MID_BOOT_10 = 14'h3e00;
    localparam logic [13:0] MID_BOOT_01 = 14'h3c00;
    localparam logic [13:0] MID_BOOT_00 = 14'h3800;
    localparam logic [13:0] MID_NONCONCURRENT_REGION_START = 14'h3800;
    localparam logic [13:0] MID_PC_MASK = 14'h3fff;
    localparam logic [7:0] MID_PAGE_MASK = 8'hff;
    localparam logic [13:0] MID_BOOT_END = 14'h3fff;
    // ==========================================================
    // Field positions inside the pointer
    localparam int WORD_LSB = 1;
    localparam int PAGE_LSB = 7;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int ARM_WINDOW_CYCLES = 4;
    localparam int PROG_TIME_US = 3700;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_BUSY
    } fsp_state_type;
endpackage : fsp_pkg

/* rtl/fsp_flash_self_prog.sv */
// Flash self-programming partition decoder and command sequencer
`timescale 1ns/1ps

module fsp_flash_self_prog #(
    parameter int PROG_CYC = fsp_pkg::PROG_CYCLES,
    parameter int CNT_W = 20
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic variant_mid,
    input wire logic boot_size_sel_hi,
    input wire logic boot_size_sel_lo,
    input wire logic [15:0] z_ptr,
    input wire logic [13:0] fetch_pc,
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    input wire logic spm_exec,
    input wire logic eeprom_write_busy,
    output logic [7:0] prog_mem_ctrl_status,
    output logic self_prog_go,
    output logic upper_region_busy,
    output logic [13:0] boot_start,
    output logic [13:0] app_end,
    output logic [11:0] boot_words,
    output logic [7:0] page_select_field,
    output logic [5:0] word_select_field,
    output logic byte_select,
    output logic erase_start,
    output logic write_start,
    output logic load_start,
    output logic fetch_allowed
);
    import fsp_pkg::*;
    // ==========================================================
    // Partition decode
    logic [1:0] bsel; // Fuse pattern
    logic [13:0] boot_start_d, boot_start_q, app_end_q; // Boot layout
    logic [11:0] boot_words_d, boot_words_q; // Boot size in words
    logic [13:0] pc_mask, nonconcurrent_region_start, fetch_word; // Per-variant limits
    logic [7:0] page_d, page_q; // Page select field
    logic fetch_nonconcurrent_region; // Fetch lies in protected region
    logic [5:0] word_q; // Buffer word select
    logic byte_q; // Byte select for reads
    // Is a word address inside the non-concurrent region
    function automatic logic in_nonconcurrent_region(input logic [13:0] a,
                                     input logic [13:0] lim);
        in_nonconcurrent_region = (a >= lim);
    endfunction : in_nonconcurrent_region
    // Fuse and variant decode, purely combinational
    always_comb begin
        bsel = {boot_size_sel_hi, boot_size_sel_lo};
        // Each step down the fuse pattern doubles the boot section
        unique case (bsel)
            2'h3: boot_words_d = variant_mid ? 12'h100 : 12'h080;
            2'h2: boot_words_d = variant_mid ? 12'h200 : 12'h100;
            2'h1: boot_words_d = variant_mid ? 12'h400 : 12'h200;
            2'h0: boot_words_d = variant_mid ? 12'h800 : 12'h400;
        endcase
        unique case (bsel)
            2'h3: boot_start_d = variant_mid ? MID_BOOT_11 : SML_BOOT_11;
            2'h2: boot_start_d = variant_mid ? MID_BOOT_10 : SML_BOOT_10;
            2'h1: boot_start_d = variant_mid ? MID_BOOT_01 : SML_BOOT_01;
            2'h0: boot_start_d = variant_mid ? MID_BOOT_00 : SML_BOOT_00;
        endcase
        pc_mask = variant_mid ? MID_PC_MASK : SML_PC_MASK;
        nonconcurrent_region_start = variant_mid ? MID_NONCONCURRENT_REGION_START : SML_NONCONCURRENT_REGION_START;
        // Small variant has only seven page bits
        page_d = z_ptr[PAGE_LSB +: 8]
            & (variant_mid ? MID_PAGE_MASK : SML_PAGE_MASK);
        fetch_word = fetch_pc & pc_mask;
        fetch_nonconcurrent_region = in_nonconcurrent_region(fetch_word, nonconcurrent_region_start);
    end
    // Register decoded layout and pointer fields for clean outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            boot_start_q <= 14'h0000;
            app_end_q <= 14'h0000;
            boot_words_q <= 12'h000;
            page_q <= 8'h00;
            word_q <= 6'h00;
            byte_q <= 1'b0;
        end else begin
            boot_start_q <= boot_start_d;
            app_end_q <= boot_start_d - 14'h0001;
            boot_words_q <= boot_words_d;
            page_q <= page_d;
            word_q <= z_ptr[WORD_LSB +: 6];
            byte_q <= z_ptr[0];
        end
    end
    // ==========================================================
    // Command sequencer
    fsp_state_type state_q, state_d;
    logic [1:0] arm_cnt_q, arm_cnt_d;     // Cycles spent armed
    logic [2:0] cmd_q, cmd_d;             // Erase, write, re-enable
    logic [CNT_W-1:0] prog_cnt_q, prog_cnt_d; // Programming timer
    logic ubusy_q, ubusy_d;               // Readable region blocked
    logic ers_q, ers_d, wrt_q, wrt_d, ld_q, ld_d;
    logic page_rww;                       // Target page is readable
    logic [13:0] page_word;
    // Next-state logic; an eeprom write blocks arming entirely
    always_comb begin
        state_d = state_q;
        arm_cnt_d = arm_cnt_q;
        cmd_d = cmd_q;
        prog_cnt_d = prog_cnt_q;
        ubusy_d = ubusy_q;
        ers_d = 1'b0;
        wrt_d = 1'b0;
        ld_d = 1'b0;
        // Page field already masked to seven bits in the small variant
        page_word = {page_d, 6'h00};
        page_rww = !in_nonconcurrent_region(page_word, nonconcurrent_region_start);
        unique case (state_q)
            ST_IDLE: begin
                if (csr_wr && csr_wdata[GO_BIT] && !eeprom_write_busy) begin
                    state_d = ST_ARMED;
                    arm_cnt_d = 2'h0;
                    cmd_d = {csr_wdata[REEN_BIT], csr_wdata[WRITE_BIT],
                             csr_wdata[ERASE_BIT]};
                end
            end
            ST_ARMED: begin
                if (spm_exec) begin
                    if (cmd_q[0] || cmd_q[1]) begin
                        // Page operation runs for the full timer
                        state_d = ST_BUSY;
                        prog_cnt_d = CNT_W'(PROG_CYC - 1);
                        ers_d = cmd_q[0];
                        wrt_d = cmd_q[1] && !cmd_q[0];
                        if (page_rww) begin
                            ubusy_d = 1'b1;
                        end
                    end else if (cmd_q[2]) begin
                        // Re-enable only reached once idle again
                        state_d = ST_IDLE;
                        ubusy_d = 1'b0;
                        cmd_d = 3'h0;
                    end else begin
                        // Plain go loads one buffer word
                        state_d = ST_IDLE;
                        ld_d = 1'b1;
                        ubusy_d = 1'b0;
                    end
                end else if (arm_cnt_q == 2'(ARM_WINDOW_CYCLES - 1)) begin
                    // Nothing followed: command bits drop away
                    state_d = ST_IDLE;
                    cmd_d = 3'h0;
                end else begin
                    arm_cnt_d = arm_cnt_q + 2'h1;
                end
            end
            ST_BUSY: begin
                if (prog_cnt_q == '0) begin
                    state_d = ST_IDLE;
                    cmd_d = 3'h0;
                end else begin
                    prog_cnt_d = prog_cnt_q - CNT_W'(1);
                end
            end
            // Unused state code falls back to idle
            default: state_d = ST_IDLE;
        endcase
    end
    // Sequencer registers
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_IDLE;
            arm_cnt_q <= 2'h0;
            cmd_q <= 3'h0;
            prog_cnt_q <= '0;
            ubusy_q <= 1'b0;
            ers_q <= 1'b0;
            wrt_q <= 1'b0;
            ld_q <= 1'b0;
        end else begin
            state_q <= state_d;
            arm_cnt_q <= arm_cnt_d;
            cmd_q <= cmd_d;
            prog_cnt_q <= prog_cnt_d;
            ubusy_q <= ubusy_d;
            ers_q <= ers_d;
            wrt_q <= wrt_d;
            ld_q <= ld_d;
        end
    end
    // ==========================================================
    // Outputs
    assign self_prog_go = (state_q != ST_IDLE);
    assign upper_region_busy = ubusy_q;
    assign prog_mem_ctrl_status = CSR_RESET
        | ({7'h00, self_prog_go} << GO_BIT)
        | ({7'h00, cmd_q[0]} << ERASE_BIT)
        | ({7'h00, cmd_q[1]} << WRITE_BIT)
        | ({7'h00, cmd_q[2]} << REEN_BIT)
        | ({7'h00, ubusy_q} << BUSY_BIT);
    assign boot_start = boot_start_q;
    assign app_end = app_end_q;
    assign boot_words = boot_words_q;
    assign page_select_field = page_q;
    assign word_select_field = word_q;
    assign byte_select = byte_q;
    assign erase_start = ers_q;
    assign write_start = wrt_q;
    assign load_start = ld_q;
    // Blocked region stalls fetch; protected region never does
    assign fetch_allowed = fetch_nonconcurrent_region
        || (!ubusy_q && state_q != ST_BUSY);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_armed_write;
        state_q == ST_IDLE && csr_wr && csr_wdata[GO_BIT]
            && !eeprom_write_busy;
    endsequence
    sequence s_no_store4;
        (!spm_exec)[*4];
    endsequence
    property p_cmd_expires;
        s_armed_write ##1 s_no_store4 |=> !self_prog_go;
    endproperty
    a_cmd_expires: assert property (p_cmd_expires)
        else $error("armed command did not expire");
    property p_store_in_window;
        s_armed_write ##4 spm_exec |=> state_q != ST_ARMED;
    endproperty
    a_store_in_window: assert property (p_store_in_window)
        else $error("store in fourth cycle was not taken");
    property p_busy_on_rww;
        (state_q == ST_ARMED && spm_exec && (cmd_q[0] || cmd_q[1])
            && page_rww) |=> upper_region_busy && (erase_start || write_start);
    endproperty
    a_busy_on_rww: assert property (p_busy_on_rww)
        else $error("busy flag not set on page operation");
    property p_load_clears;
        load_start |-> !upper_region_busy && !self_prog_go;
    endproperty
    a_load_clears: assert property (p_load_clears)
        else $error("page load left busy flag set");
    property p_fetch_block;
        (upper_region_busy && !fetch_nonconcurrent_region) |-> !fetch_allowed;
    endproperty
    a_fetch_block: assert property (p_fetch_block)
        else $error("readable region fetched while busy");
    property p_prog_fetch;
        (state_q == ST_BUSY) |-> fetch_allowed == fetch_nonconcurrent_region;
    endproperty
    a_prog_fetch: assert property (p_prog_fetch)
        else $error("fetch outside protected region while programming");
    property p_small_boot;
        (!variant_mid && bsel == 2'h3) |=> boot_start == 14'h1f80
            && boot_words == 12'h080 && app_end == 14'h1f7f;
    endproperty
    a_small_boot: assert property (p_small_boot)
        else $error("small variant boot decode wrong");
    property p_mid_boot;
        (variant_mid && bsel == 2'h0) |=> boot_start == 14'h3800
            && boot_words == 12'h800;
    endproperty
    a_mid_boot: assert property (p_mid_boot)
        else $error("middle variant boot decode wrong");
    property p_small_split;
        !variant_mid |-> fetch_nonconcurrent_region == (fetch_pc[12:0] >= 13'h1c00);
    endproperty
    a_small_split: assert property (p_small_split)
        else $error("small variant region split wrong");
    property p_mid_split;
        variant_mid |-> fetch_nonconcurrent_region == (fetch_pc >= 14'h3800);
    endproperty
    a_mid_split: assert property (p_mid_split)
        else $error("middle variant region split wrong");
    property p_word_field;
        1'b1 |=> word_select_field == $past(z_ptr[6:1]);
    endproperty
    a_word_field: assert property (p_word_field)
        else $error("word select not pointer bits 6 to 1");
endmodule : fsp_flash_self_prog

/* tb/fsp_loader_model.sv */
// Boot loader software model issuing timed store-program sequences
`timescale 1ns/1ps
module fsp_loader_model (
    input wire logic clock,
    input wire logic [7:0] prog_mem_ctrl_status,
    input wire logic eeprom_write_busy,
    output logic csr_wr,
    output logic [7:0] csr_wdata,
    output logic spm_exec
);
    import fsp_pkg::*;
    // ==========================================================
    // Software state
    logic irq_on_q; // Interrupt enable, masked during timed step

    initial begin
        csr_wr = 1'b0;
        csr_wdata = 8'h00;
        spm_exec = 1'b0;
        irq_on_q = 1'b1;
    end

    // ==========================================================
    // One timed command, entered just after a clock edge
    // Store lands dly+1 edges after the control write; rude skips the
    // polite waits so that refusals can be provoked on purpose
    task automatic do_spm(input logic [7:0] cmd, input int dly,
                          input logic store, input logic rude);
        logic saved;
        int guard;
        guard = 0;
        // Previous command must be over before a new one
        while (!rude && prog_mem_ctrl_status[GO_BIT] !== 1'b0 &&
               guard < 2000) begin
            @(posedge clock);
            #1;
            guard++;
        end
        saved = irq_on_q;
        irq_on_q = 1'b0;
        // Eeprom write blocks arming, so wait it out
        while (!rude && eeprom_write_busy !== 1'b0 &&
               guard < 2000) begin
            @(posedge clock);
            #1;
            guard++;
        end
        csr_wr = 1'b1;
        csr_wdata = cmd;
        @(posedge clock);
        #1;
        csr_wr = 1'b0;
        csr_wdata = ~cmd; // Released data never shows the last value
        repeat (dly) begin
            @(posedge clock);
            #1;
        end
        spm_exec = store;
        @(posedge clock);
        #1;
        spm_exec = 1'b0;
        irq_on_q = saved;
    endtask : do_spm
endmodule : fsp_loader_model

/* tb/testbench.sv */
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module testbench;
    import fsp_pkg::*;
    logic clock, srst, variant_mid, boot_size_sel_hi, boot_size_sel_lo;
    logic [15:0] z_ptr;
    logic [13:0] fetch_pc, boot_start, app_end, lim;
    logic csr_wr, spm_exec, eeprom_write_busy, self_prog_go;
    logic [7:0] csr_wdata, prog_mem_ctrl_status, page_select_field;
    logic upper_region_busy, byte_select, fetch_allowed;
    logic erase_start, write_start, load_start;
    logic [11:0] boot_words;
    logic [5:0] word_select_field;
    logic [15:0] ew, es;
    logic [16:0] lfsr;
    logic [2:0] exp_q[$]; // Expected start kind: erase, write, load
    int bad_count, n_compared, cycles;

    fsp_flash_self_prog #(.PROG_CYC(20), .CNT_W(20)) dut (.clock(clock),
        .srst(srst), .variant_mid(variant_mid),
        .boot_size_sel_hi(boot_size_sel_hi),
        .boot_size_sel_lo(boot_size_sel_lo), .z_ptr(z_ptr),
        .fetch_pc(fetch_pc), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
        .spm_exec(spm_exec), .eeprom_write_busy(eeprom_write_busy),
        .prog_mem_ctrl_status(prog_mem_ctrl_status),
        .self_prog_go(self_prog_go), .upper_region_busy(upper_region_busy),
        .boot_start(boot_start), .app_end(app_end), .boot_words(boot_words),
        .page_select_field(page_select_field),
        .word_select_field(word_select_field), .byte_select(byte_select),
        .erase_start(erase_start), .write_start(write_start),
        .load_start(load_start), .fetch_allowed(fetch_allowed));
    fsp_loader_model ldr (.clock(clock),
        .prog_mem_ctrl_status(prog_mem_ctrl_status),
        .eeprom_write_busy(eeprom_write_busy), .csr_wr(csr_wr),
        .csr_wdata(csr_wdata), .spm_exec(spm_exec));

    // ==========================================================
    // Helpers
    function automatic logic [16:0] lfsr_next(input logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction : lfsr_next

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick

    task automatic wait_idle();
        for (int g = 0; g < 100 && self_prog_go !== 1'b0; g++) tick();
    endtask : wait_idle

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // Clock, hang guard and start-pulse monitor
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("[FAIL] timeout expected done seen hung");
            conclude();
        end
    end

    // Oldest note is taken whenever any start pulse shows
    always @(posedge clock) begin
        if (srst === 1'b0 && {erase_start, write_start, load_start} !== 0) begin
            if (exp_q.size() == 0) begin
                check("stray_start", 16'({erase_start, write_start,
                      load_start}), 16'h0);
            end else begin
                check("start_kind", 16'({erase_start, write_start,
                      load_start}), 16'(exp_q.pop_front()));
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        {srst, variant_mid, boot_size_sel_hi, boot_size_sel_lo} = 4'b1000;
        {z_ptr, fetch_pc, eeprom_write_busy} = '0;
        lfsr = 17'd77706;
        repeat (20) @(posedge clock);
        #1 srst = 1'b0;
        tick();
        check("rst_status", 16'(prog_mem_ctrl_status), 16'h0);
        // Boot section decode: pattern 11 smallest, each step doubles
        for (int i = 0; i < 8; i++) begin
            variant_mid = i[2];
            {boot_size_sel_hi, boot_size_sel_lo} = i[1:0];
            tick();
            ew = (i[2] ? 16'd256 : 16'd128) << (3 - i[1:0]);
            es = (i[2] ? 16'h4000 : 16'h2000) - ew;
            check("boot_start", 16'(boot_start), es);
            check("boot_words", 16'(boot_words), ew);
            check("app_end", 16'(app_end), es - 16'h1);
        end
        $display("test decode done");
        // Pointer fields from random pointers
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            variant_mid = lfsr[16];
            z_ptr = lfsr[15:0];
            tick();
            check("page", 16'(page_select_field), 16'(z_ptr[14:7] &
                  (variant_mid ? 8'hff : 8'h7f)));
            check("word", 16'(word_select_field), 16'(z_ptr[6:1]));
            check("byte", 16'(byte_select), 16'(z_ptr[0]));
        end
        $display("test fields done");
        // Erase in readable region, both variants, fast and late store
        z_ptr = 16'h0100;
        for (int v = 0; v < 2; v++) begin
            variant_mid = v[0];
            lim = v ? 14'h3800 : 14'h1c00;
            exp_q.push_back(3'b100);
            ldr.do_spm(v ? 8'h07 : 8'h03, v * 3, 1'b1, 1'b0);
            fetch_pc = lim - 14'h1;
            tick();
            check("busy_set", 16'(upper_region_busy), 16'h1);
            es = v ? 16'h47 : 16'h43; // Go, command bits and busy flag
            check("status_busy", 16'(prog_mem_ctrl_status), es);
            check("fetch_rww", 16'(fetch_allowed), 16'h0);
            fetch_pc = lim;
            tick();
            check("fetch_nonconcurrent_region", 16'(fetch_allowed), 16'h1);
            ldr.do_spm(8'h05, 0, 1'b1, 1'b1); // Refused while busy
            wait_idle();
            fetch_pc = lim - 14'h1;
            check("busy_hold", 16'(upper_region_busy), 16'h1);
            ldr.do_spm(8'h11, 1, 1'b1, 1'b0);
            tick();
            check("busy_clr", 16'(upper_region_busy), 16'h0);
            check("status_clr", 16'(prog_mem_ctrl_status), 16'h0);
            check("fetch_back", 16'(fetch_allowed), 16'h1);
        end
        $display("test erase done");
        // Eeprom write refuses arming; unanswered arming expires
        variant_mid = 1'b0;
        eeprom_write_busy = 1'b1;
        ldr.do_spm(8'h05, 0, 1'b1, 1'b1);
        check("go_ee", 16'(self_prog_go), 16'h0);
        eeprom_write_busy = 1'b0;
        ldr.do_spm(8'h05, 2, 1'b0, 1'b0);
        check("go_armed", 16'(self_prog_go), 16'h1);
        check("status_armed", 16'(prog_mem_ctrl_status), 16'h5);
        repeat (2) tick();
        check("go_expired", 16'(self_prog_go), 16'h0);
        $display("test refuse done");
        // Page write then two buffer loads, pointer stepping two bytes
        exp_q.push_back(3'b010);
        ldr.do_spm(8'h05, 1, 1'b1, 1'b0);
        for (int w = 0; w < 2; w++) begin
            z_ptr = 16'h0100 + 16'(2 * w);
            exp_q.push_back(3'b001);
            ldr.do_spm(8'h01, w, 1'b1, 1'b0);
            tick();
            check("load_busy", 16'(upper_region_busy), 16'h0);
            check("load_word", 16'(word_select_field), 16'(w));
        end
        repeat (2) tick();
        check("notes_left", 16'(exp_q.size()), 16'h0);
        $display("test fill done");
        conclude();
    end
endmodule : testbench
